// File: rtl/async_serial_tx_rx_core.sv
// asynchronous serial transmitter and receiver with a classic wishbone register slave
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "async_serial_defines.svh"
module async_serial_tx_rx_core (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic tx_pin_o,
    output logic tx_pin_oe,
    input wire logic rx_pin_i,
    output logic rx_pin_ie,
    output logic tx_irq,
    output logic rx_irq
);
    logic serial_enable_r, tx_polarity_flip_r, char_nine_bit_select_r;
    logic send_break_ctl_r, tx_on_r, tx_empty_irq_en_r, tx_done_irq_en_r, rx_full_irq_en_r;
    logic tx_ninth_bit_r, rx_ninth_bit_r;
    logic tx_buffer_empty_r, tx_done_flag_r, rx_full_flag_r, noise_flag_r;
    logic framing_error_flag_r, overrun_flag_r, break_seen_flag_r;
    logic [7:0] tx_data_r, serial_data_buffer_r;
    logic [15:0] baud_div_r, baud_cnt_r;
    logic sample_tick_r;
    logic [3:0] tx_phase_r, tx_cnt_r;
    logic [10:0] tx_sh_r;
    logic tx_active_r, in_break_r, idle_q_r;
    logic rx_meta_r, rx_sync_r;
    async_serial_pkg::rx_state_t rx_state_r;
    logic [2:0] hist_r, samp_r;
    logic [3:0] rt_r, bit_idx_r;
    logic [8:0] rx_sh_r;
    logic prev_bit_r, start_noise_r;

    logic wr, rd, bus_req;
    logic bit_edge, reload, ld_break, ld_tail, ld_idle, ld_data;
    logic [3:0] char_len;
    logic maj, disagree, last_bit, resync;
    logic [31:0] rd_val;
    logic [2:0] win;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = bus_req && wb_we_i && wb_sel_i[0];
    assign rd = bus_req && !wb_we_i;
    assign char_len = char_nine_bit_select_r ? `LEN_NINE : `LEN_EIGHT;

    // classic wishbone: one wait state, ack for one cycle, unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd ? rd_val : 32'h00000000;
        end
    end

    always_comb begin
        rd_val = 32'h00000000;
        if (wb_adr_i == `OFF_CTRL_ONE) begin
            rd_val[`C1_ENABLE] = serial_enable_r;
            rd_val[`C1_INVERT] = tx_polarity_flip_r;
            rd_val[`C1_NINE] = char_nine_bit_select_r;
        end else if (wb_adr_i == `OFF_CTRL_TWO) begin
            rd_val[`C2_BREAK] = send_break_ctl_r;
            rd_val[`C2_TX_ON] = tx_on_r;
            rd_val[`C2_TE_IE] = tx_empty_irq_en_r;
            rd_val[`C2_TC_IE] = tx_done_irq_en_r;
            rd_val[`C2_RF_IE] = rx_full_irq_en_r;
        end else if (wb_adr_i == `OFF_CTRL_THREE) begin
            rd_val[`C3_TX_NINTH] = tx_ninth_bit_r;
            rd_val[`C3_RX_NINTH] = rx_ninth_bit_r;
        end else if (wb_adr_i == `OFF_STAT_ONE) begin
            rd_val[`S1_TBE] = tx_buffer_empty_r;
            rd_val[`S1_DONE] = tx_done_flag_r;
            rd_val[`S1_RFULL] = rx_full_flag_r;
            rd_val[`S1_NOISE] = noise_flag_r;
            rd_val[`S1_FRAME] = framing_error_flag_r;
            rd_val[`S1_OVERRUN] = overrun_flag_r;
        end else if (wb_adr_i == `OFF_STAT_TWO) begin
            rd_val[`S2_BREAK] = break_seen_flag_r;
            rd_val[`S2_BUSY] = (rx_state_r != async_serial_pkg::RX_HUNT);
        end else if (wb_adr_i == `OFF_DATA) begin
            rd_val[7:0] = serial_data_buffer_r;
        end else if (wb_adr_i == `OFF_BAUD) begin
            rd_val[15:0] = baud_div_r;
        end
    end

    // control registers; the low byte lane carries every control bit, the baud divisor also needs lane one
    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_enable_r <= 1'b0;
            tx_polarity_flip_r <= 1'b0;
            char_nine_bit_select_r <= 1'b0;
            send_break_ctl_r <= 1'b0;
            tx_on_r <= 1'b0;
            tx_empty_irq_en_r <= 1'b0;
            tx_done_irq_en_r <= 1'b0;
            rx_full_irq_en_r <= 1'b0;
            tx_ninth_bit_r <= 1'b0;
            baud_div_r <= `BAUD_RESET;
        end else if (wr) begin
            if (wb_adr_i == `OFF_CTRL_ONE) begin
                serial_enable_r <= wb_dat_i[`C1_ENABLE];
                tx_polarity_flip_r <= wb_dat_i[`C1_INVERT];
                char_nine_bit_select_r <= wb_dat_i[`C1_NINE];
            end else if (wb_adr_i == `OFF_CTRL_TWO) begin
                send_break_ctl_r <= wb_dat_i[`C2_BREAK];
                tx_on_r <= wb_dat_i[`C2_TX_ON];
                tx_empty_irq_en_r <= wb_dat_i[`C2_TE_IE];
                tx_done_irq_en_r <= wb_dat_i[`C2_TC_IE];
                rx_full_irq_en_r <= wb_dat_i[`C2_RF_IE];
            end else if (wb_adr_i == `OFF_CTRL_THREE) begin
                tx_ninth_bit_r <= wb_dat_i[`C3_TX_NINTH];
            end else if (wb_adr_i == `OFF_BAUD && wb_sel_i[1]) begin
                baud_div_r <= wb_dat_i[15:0];
            end
        end
    end

    // sample tick generator, period baud_div_r + 1 clocks
    always_ff @(posedge clk) begin
        if (!rstn || !serial_enable_r) begin
            baud_cnt_r <= 16'h0000;
            sample_tick_r <= 1'b0;
        end else begin
            sample_tick_r <= (baud_cnt_r >= baud_div_r);
            baud_cnt_r <= (baud_cnt_r >= baud_div_r) ? 16'h0000 : baud_cnt_r + 16'h0001;
        end
    end

    // transmitter bit timing: sixteen sample ticks per bit
    always_ff @(posedge clk) begin
        if (!rstn || !serial_enable_r) begin
            tx_phase_r <= 4'h0;
        end else if (sample_tick_r) begin
            tx_phase_r <= tx_phase_r + 4'h1;
        end
    end

    assign bit_edge = sample_tick_r && (tx_phase_r == `RT_LAST);
    assign reload = bit_edge && !(tx_active_r && tx_cnt_r > 4'h1);
    assign ld_break = reload && send_break_ctl_r;
    assign ld_tail = reload && !send_break_ctl_r && in_break_r;
    // a queued idle only goes out while tx_on is set; dropping tx_on just idles the line
    assign ld_idle = reload && !send_break_ctl_r && !in_break_r && idle_q_r && tx_on_r;
    assign ld_data = reload && !send_break_ctl_r && !in_break_r && !ld_idle && tx_on_r
        && !idle_q_r && !tx_buffer_empty_r;

    always_ff @(posedge clk) begin
        if (!rstn || !serial_enable_r) begin
            tx_active_r <= 1'b0;
            tx_cnt_r <= 4'h0;
            tx_sh_r <= 11'h7FF;
            in_break_r <= 1'b0;
        end else if (bit_edge) begin
            if (!reload) begin
                tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
            end else if (ld_break) begin
                tx_sh_r <= 11'h000;
                tx_cnt_r <= char_len;
                tx_active_r <= 1'b1;
                in_break_r <= 1'b1;
            end else if (ld_tail) begin
                tx_sh_r <= 11'h7FF;
                tx_cnt_r <= 4'h1;
                in_break_r <= 1'b0;
            end else if (ld_idle) begin
                tx_sh_r <= 11'h7FF;
                tx_cnt_r <= char_len;
                tx_active_r <= 1'b1;
            end else if (ld_data) begin
                // start in bit 0, data lsb first, ninth bit or stop after
                tx_sh_r <= {1'b1, char_nine_bit_select_r ? tx_ninth_bit_r : 1'b1,
                    tx_data_r, 1'b0};
                tx_cnt_r <= char_len;
                tx_active_r <= 1'b1;
            end else begin
                tx_active_r <= 1'b0;
            end
        end
    end

    // raising tx_on queues an idle character, which is also the preamble
    always_ff @(posedge clk) begin
        if (!rstn || !serial_enable_r) begin
            idle_q_r <= 1'b0;
        end else if (wr && wb_adr_i == `OFF_CTRL_TWO && wb_dat_i[`C2_TX_ON] && !tx_on_r) begin
            idle_q_r <= 1'b1;
        end else if (ld_idle) begin
            idle_q_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_buffer_empty_r <= 1'b1;
            tx_data_r <= 8'h00;
        end else if (!serial_enable_r) begin
            tx_buffer_empty_r <= 1'b1;
        end else if (ld_data) begin
            tx_buffer_empty_r <= 1'b1;
        end else if (wr && wb_adr_i == `OFF_DATA) begin
            tx_data_r <= wb_dat_i[7:0];
            tx_buffer_empty_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_done_flag_r <= 1'b1;
        end else begin
            tx_done_flag_r <= !serial_enable_r || (!tx_active_r && tx_buffer_empty_r
                && !send_break_ctl_r && !in_break_r && !idle_q_r);
        end
    end

    // pin drivers; enable drops releases the pins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_pin_o <= 1'b1;
            tx_pin_oe <= 1'b0;
            rx_pin_ie <= 1'b0;
        end else begin
            tx_pin_o <= (tx_active_r ? tx_sh_r[0] : 1'b1) ^ tx_polarity_flip_r;
            tx_pin_oe <= serial_enable_r;
            rx_pin_ie <= serial_enable_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= serial_enable_r && ((tx_buffer_empty_r && tx_empty_irq_en_r)
                || (tx_done_flag_r && tx_done_irq_en_r));
            rx_irq <= rx_full_flag_r && rx_full_irq_en_r;
        end
    end

    // receiver: pin synchroniser
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rx_pin_i;
            rx_sync_r <= rx_meta_r;
        end
    end

    assign win = {samp_r[1:0], rx_sync_r};
    assign maj = (win[0] & win[1]) | (win[0] & win[2]) | (win[1] & win[2]);
    assign disagree = (win != 3'b000) && (win != 3'b111);
    assign last_bit = (bit_idx_r == char_len - 4'h1);
    // a late one-to-zero edge inside a bit restarts the tick count there
    assign resync = prev_bit_r && (rt_r >= `RT_RESYNC) && !rx_sync_r && hist_r[0]
        && !last_bit;

    always_ff @(posedge clk) begin
        if (!rstn || !serial_enable_r) begin
            rx_state_r <= async_serial_pkg::RX_HUNT;
            hist_r <= 3'b000;
            samp_r <= 3'b000;
            rt_r <= 4'h0;
            bit_idx_r <= 4'h0;
            rx_sh_r <= 9'h000;
            prev_bit_r <= 1'b0;
            start_noise_r <= 1'b0;
        end else if (sample_tick_r) begin
            hist_r <= {hist_r[1:0], rx_sync_r};
            case (rx_state_r)
                async_serial_pkg::RX_HUNT: begin
                    if (hist_r == 3'b111 && !rx_sync_r) begin
                        rx_state_r <= async_serial_pkg::RX_START;
                        rt_r <= 4'h1;
                        bit_idx_r <= 4'h0;
                        start_noise_r <= 1'b0;
                    end
                end
                async_serial_pkg::RX_START: begin
                    rt_r <= rt_r + 4'h1;
                    if (rt_r + 4'h1 == `RT_S3 || rt_r + 4'h1 == `RT_S5) begin
                        samp_r <= {samp_r[1:0], rx_sync_r};
                    end
                    if (rt_r + 4'h1 == `RT_S7) begin
                        // more than one of three is one: not a start
                        if ((samp_r[1] & samp_r[0]) | (samp_r[1] & rx_sync_r)
                            | (samp_r[0] & rx_sync_r)) begin
                            rx_state_r <= async_serial_pkg::RX_HUNT;
                            hist_r <= 3'b000;
                        end else begin
                            start_noise_r <= samp_r[1] | samp_r[0] | rx_sync_r;
                        end
                    end
                    if (rt_r + 4'h1 == `RT_S8 || rt_r + 4'h1 == `RT_S9) begin
                        samp_r <= {samp_r[1:0], rx_sync_r};
                    end
                    if (rt_r + 4'h1 == `RT_S10 && win != 3'b000) begin
                        start_noise_r <= 1'b1;
                    end
                    if (rt_r == `RT_LAST) begin
                        rt_r <= 4'h0;
                        bit_idx_r <= 4'h1;
                        prev_bit_r <= 1'b0;
                        rx_state_r <= async_serial_pkg::RX_BITS;
                    end
                end
                default: begin
                    rt_r <= rt_r + 4'h1;
                    if (rt_r + 4'h1 == `RT_S8 || rt_r + 4'h1 == `RT_S9) begin
                        samp_r <= {samp_r[1:0], rx_sync_r};
                    end
                    if (rt_r + 4'h1 == `RT_S10) begin
                        prev_bit_r <= maj;
                        if (last_bit) begin
                            rx_state_r <= async_serial_pkg::RX_HUNT;
                            hist_r <= 3'b000;
                        end else begin
                            rx_sh_r[bit_idx_r - 4'h1] <= maj;
                        end
                    end
                    if (resync) begin
                        rt_r <= 4'h1;
                        bit_idx_r <= bit_idx_r + 4'h1;
                        prev_bit_r <= 1'b0;
                    end else if (rt_r == `RT_LAST) begin
                        rt_r <= 4'h0;
                        bit_idx_r <= bit_idx_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // end of stop bit sampling: hand the character over
    logic char_done, is_break, data_rd, st_wr;
    assign char_done = sample_tick_r && rx_state_r == async_serial_pkg::RX_BITS
        && rt_r + 4'h1 == `RT_S10 && last_bit;
    assign is_break = !maj && (char_nine_bit_select_r ? rx_sh_r == 9'h000
        : rx_sh_r[7:0] == 8'h00);
    assign data_rd = rd && wb_adr_i == `OFF_DATA;
    assign st_wr = wr && (wb_adr_i == `OFF_STAT_ONE);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_data_buffer_r <= 8'h00;
            rx_ninth_bit_r <= 1'b0;
        // a read in the same cycle frees the buffer, so the new character is kept
        end else if (char_done && (is_break || !rx_full_flag_r || data_rd)) begin
            if (is_break) begin
                serial_data_buffer_r <= 8'h00;
                rx_ninth_bit_r <= 1'b0;
            end else begin
                serial_data_buffer_r <= rx_sh_r[7:0];
                rx_ninth_bit_r <= char_nine_bit_select_r ? rx_sh_r[8] : rx_sh_r[7];
            end
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_full_flag_r <= 1'b0;
            overrun_flag_r <= 1'b0;
            framing_error_flag_r <= 1'b0;
            noise_flag_r <= 1'b0;
            break_seen_flag_r <= 1'b0;
        end else begin
            if (char_done) begin
                rx_full_flag_r <= 1'b1;
            end else if (data_rd) begin
                rx_full_flag_r <= 1'b0;
            end
            if (char_done && rx_full_flag_r && !data_rd) begin
                overrun_flag_r <= 1'b1;
            end else if (st_wr && wb_dat_i[`S1_OVERRUN]) begin
                overrun_flag_r <= 1'b0;
            end
            if (char_done && !maj) begin
                framing_error_flag_r <= 1'b1;
            end else if (st_wr && wb_dat_i[`S1_FRAME]) begin
                framing_error_flag_r <= 1'b0;
            end
            if ((char_done && (disagree || start_noise_r)) || (sample_tick_r
                && rx_state_r == async_serial_pkg::RX_BITS && rt_r + 4'h1 == `RT_S10
                && disagree)) begin
                noise_flag_r <= 1'b1;
            end else if (st_wr && wb_dat_i[`S1_NOISE]) begin
                noise_flag_r <= 1'b0;
            end
            if (char_done && is_break) begin
                break_seen_flag_r <= 1'b1;
            end else if (wr && wb_adr_i == `OFF_STAT_TWO && wb_dat_i[`S2_BREAK]) begin
                break_seen_flag_r <= 1'b0;
            end
        end
    end
endmodule : async_serial_tx_rx_core

// File: rtl/async_serial_defines.svh
// register offsets, field positions, reset values and timing counts of the serial core
`ifndef ASYNC_SERIAL_DEFINES_SVH
`define ASYNC_SERIAL_DEFINES_SVH
`define OFF_CTRL_ONE 8'h00
`define OFF_CTRL_TWO 8'h04
`define OFF_CTRL_THREE 8'h08
`define OFF_STAT_ONE 8'h0C
`define OFF_STAT_TWO 8'h10
`define OFF_DATA 8'h14
`define OFF_BAUD 8'h18
`define C1_ENABLE 0
`define C1_INVERT 1
`define C1_NINE 2
`define C2_BREAK 0
`define C2_TX_ON 1
`define C2_TE_IE 2
`define C2_TC_IE 3
`define C2_RF_IE 4
`define C3_TX_NINTH 0
`define C3_RX_NINTH 1
`define S1_TBE 0
`define S1_DONE 1
`define S1_RFULL 2
`define S1_NOISE 3
`define S1_FRAME 4
`define S1_OVERRUN 5
`define S2_BREAK 0
`define S2_BUSY 1
`define BAUD_RESET 16'h0001
`define RT_LAST 4'hF
`define RT_S3 4'h3
`define RT_S5 4'h5
`define RT_S7 4'h7
`define RT_S8 4'h8
`define RT_S9 4'h9
`define RT_S10 4'hA
`define RT_RESYNC 4'hD
`define LEN_EIGHT 4'hA
`define LEN_NINE 4'hB
`endif

// File: rtl/async_serial_pkg.sv
// types shared by the serial core
package async_serial_pkg;
    typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_state_t;
endpackage : async_serial_pkg

// File: testbench/async_serial_checker.sv
// port-level assertions for the serial core
`timescale 1ns/1ps
module async_serial_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic tx_pin_o,
    input wire logic tx_pin_oe,
    input wire logic rx_pin_ie,
    input wire logic tx_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_pins_owned: assert property (tx_pin_oe == rx_pin_ie)
        else $error("pin ownership differs");
    chk_irq_masked: assert property (!tx_pin_oe [*2] |-> !tx_irq)
        else $error("tx irq while disabled");
    chk_bit_holds: assert property (tx_pin_oe && $changed(tx_pin_o)
        |=> $stable(tx_pin_o) [*8])
        else $error("tx level shorter than a bit");
    chk_reset_idle: assert property ($rose(rstn) |-> tx_pin_o && !tx_pin_oe)
        else $error("tx pin not idle after reset");
    cover property (wb_cyc_i && wb_stb_i && wb_ack_o);
    cover property (tx_pin_oe && $fell(tx_pin_o));
    cover property ($rose(tx_irq));
endmodule : async_serial_checker
bind async_serial_tx_rx_core async_serial_checker i_chk (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .rx_pin_ie(rx_pin_ie), .tx_irq(tx_irq));

// File: testbench/serial_peer.sv
// remote serial device model on the far side of the pins
`timescale 1ns/1ps
module serial_peer #(parameter int BT = 16) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    // idle mark gives the three ones a start search needs
    initial line_out = 1'b1;
    // g picks a bit that gets a one-clock glitch near its centre
    task automatic send(input logic [8:0] d, input int n, input logic stop, input int g);
        logic b;
        for (int i = 0; i <= n + 1; i++) begin
            b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stop;
            for (int c = 0; c < BT; c++) begin
                @(posedge clk);
                line_out <= (i == g && c == 8) ? ~b : b;
            end
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask : send
    task automatic recv(input int n, input logic inv, output logic [8:0] d, output int wt);
        wt = 0;
        d = 9'h000;
        @(posedge clk);
        while ((line_in ^ inv) !== 1'b0) begin
            @(posedge clk);
            wt++;
        end
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (BT) @(posedge clk);
            d[i] = line_in ^ inv;
        end
        repeat (2 * BT) @(posedge clk);
    endtask : recv
endmodule : serial_peer

// File: testbench/test_async_serial_tx_rx_core.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`include "async_serial_defines.svh"
module test_async_serial_tx_rx_core;
    localparam int BT = 16;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack, txd, txoe, rxd, rxie, tx_irq, rx_irq;
    logic [31:0] q;
    logic [8:0] d;
    int wt;
    int n_mismatch = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    async_serial_tx_rx_core i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .tx_pin_o(txd), .tx_pin_oe(txoe), .rx_pin_i(rxd), .rx_pin_ie(rxie),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    serial_peer #(.BT(BT)) i_peer (.clk(clk), .line_in(txd), .line_out(rxd));
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
        // registered outputs that follow a write settle one edge later
        @(posedge clk);
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h", $time, m, got);
        end
    endtask : chk
    task automatic t_tx();
        wb(1, `OFF_CTRL_TWO, 32'h02);
        wb(1, `OFF_DATA, 32'hA5);
        i_peer.recv(8, 1'b0, d, wt);
        chk(d, 9'h0A5, "tx data");
        chk(wt >= 9 * BT, 1, "preamble");
        wb(0, `OFF_STAT_ONE, 0);
        chk(q & 32'h3, 32'h3, "empty and done");
        wb(1, `OFF_CTRL_TWO, 32'h0A);
        chk(tx_irq, 1, "done irq");
        wb(1, `OFF_CTRL_TWO, 32'h06);
        chk(tx_irq, 1, "empty irq");
        wb(1, `OFF_CTRL_TWO, 32'h00);
        // tx_on back up while tx_buffer_empty is set and before the next buffer write
        wb(1, `OFF_CTRL_TWO, 32'h02);
        wb(1, `OFF_DATA, 32'hC3);
        i_peer.recv(8, 1'b0, d, wt);
        chk(d, 9'h0C3, "data after queued idle");
        chk(wt >= 9 * BT, 1, "queued idle");
        wb(1, `OFF_CTRL_ONE, 32'h05);
        wb(1, `OFF_CTRL_THREE, 32'h01);
        wb(1, `OFF_DATA, 32'h3C);
        i_peer.recv(9, 1'b0, d, wt);
        chk(d, 9'h13C, "nine bit tx");
        wb(1, `OFF_CTRL_ONE, 32'h03);
        // keep the polarity step a full bit away from the next frame edge
        repeat (BT) @(posedge clk);
        chk(txd, 0, "inverted idle");
        wb(1, `OFF_DATA, 32'h5A);
        i_peer.recv(8, 1'b1, d, wt);
        chk(d, 9'h05A, "inverted frame");
        wb(1, `OFF_CTRL_ONE, 32'h01);
        repeat (BT) @(posedge clk);
        $display("test tx done");
    endtask : t_tx
    task automatic t_break();
        logic seen;
        seen = 1'b0;
        wb(1, `OFF_CTRL_TWO, 32'h03);
        for (int i = 0; i < 12 * BT && txd !== 1'b0; i++) @(posedge clk);
        repeat (BT / 2) @(posedge clk);
        // two and a half break lengths must stay low back to back
        for (int i = 0; i < 25; i++) begin
            seen |= txd;
            repeat (BT) @(posedge clk);
        end
        chk(seen, 0, "break low");
        wb(1, `OFF_CTRL_TWO, 32'h12);
        for (int i = 0; i < 12 * BT && txd !== 1'b1; i++) @(posedge clk);
        chk(txd, 1, "mark after break");
        $display("test break done");
    endtask : t_break
    task automatic t_rx(input logic [8:0] v, input logic stop, input int g,
        input logic [31:0] st, input logic [31:0] nin);
        i_peer.send(v, 8, stop, g);
        repeat (2 * BT) @(posedge clk);
        chk(rx_irq, 1, "rx irq");
        wb(0, `OFF_STAT_ONE, 0);
        chk(q & 32'h1C, st, "rx status");
        wb(0, `OFF_CTRL_THREE, 0);
        chk(q & 32'h2, nin, "rx ninth");
        wb(0, `OFF_DATA, 0);
        chk(q, {24'h0, v[7:0]}, "rx data");
        wb(1, `OFF_STAT_ONE, 32'h38);
        $display("test rx done");
    endtask : t_rx
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // generous bound: the whole run needs about 3000 clocks
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        wb(0, `OFF_STAT_ONE, 0);
        chk(q, 32'h3, "status reset");
        wb(0, `OFF_CTRL_ONE, 0);
        chk(q, 32'h0, "length select reset");
        wb(0, 8'hFC, 0);
        chk(q, 32'h0, "unmapped read");
        wb(1, `OFF_BAUD, 32'h0);
        wb(1, `OFF_CTRL_ONE, 32'h01);
        chk({txoe, rxie}, 2'b11, "pins owned");
        t_tx();
        t_break();
        t_rx(9'h096, 1'b1, -1, 32'h04, 32'h2);
        t_rx(9'h03C, 1'b1, 3, 32'h0C, 32'h0);
        t_rx(9'h05A, 1'b1, 0, 32'h0C, 32'h0);
        t_rx(9'h000, 1'b0, -1, 32'h14, 32'h0);
        wb(0, `OFF_STAT_TWO, 0);
        chk(q & 32'h1, 32'h1, "break seen");
        wb(1, `OFF_CTRL_ONE, 32'h00);
        wb(0, `OFF_STAT_ONE, 0);
        chk({txoe, rxie, q[1:0]}, 4'h3, "disabled");
        $display("test disable done");
        wrap_up();
    end
endmodule : test_async_serial_tx_rx_core
